// ---- src/ubrg_cfg.svh ----
// Register map, field positions, reset values and divider constants of the baud rate generator.
// Assumes it is included by bare name from files that also see ubrg_pkg.
`ifndef UBRG_CFG_SVH
`define UBRG_CFG_SVH

// Byte offsets on the APB register bus.
`define UBRG_OFS_MODE        12'h000
`define UBRG_OFS_DIV         12'h004
`define UBRG_OFS_STAT        12'h008

// Field positions inside mode_config_register.
`define UBRG_MODE_OPMODE_LSB 0
`define UBRG_MODE_CLKSRC_LSB 4
`define UBRG_MODE_SYNC_BIT   8
`define UBRG_MODE_OVER_BIT   9

// Field positions inside divider_config_register.
`define UBRG_DIV_CD_LSB      0
`define UBRG_DIV_FP_LSB      16

// Field positions inside the status register.
`define UBRG_STAT_CNT_LSB    0
`define UBRG_STAT_IDX_LSB    16
`define UBRG_STAT_GATE_BIT   20

// Reset values.
`define UBRG_RST_OPMODE      4'h0
`define UBRG_RST_CLKSRC      2'h0
`define UBRG_RST_CLKDIV      16'h0000
`define UBRG_RST_FRAC        3'h0

// Operating mode code that counts as normal mode.
`define UBRG_OPMODE_NORMAL   4'h0

// Clock source codes.
`define UBRG_SRC_PCLK        2'h0
`define UBRG_SRC_EXT         2'h3

// Fixed prescaler of the divided peripheral clock source, and its last count.
`define UBRG_PRESCALE_LAST   3'h7

// Last oversampling index for 16x and 8x sampling.
`define UBRG_LAST_IDX_X16    4'hF
`define UBRG_LAST_IDX_X8     4'h7

`endif

// ---- src/ubrg_pkg.sv ----
// Types shared by the baud rate generator and its pin synchroniser.
// Assumes the constants of ubrg_cfg.svh for field widths and values.
package ubrg_pkg;

	// State of the external clock pin synchroniser.
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic rise;
	} ubrg_pin_state_t;

	// Complete state of the generator: register copy, divider chain and bus read data.
	typedef struct packed {
		logic [31:0] prdata;
		logic [3:0]  opMode;
		logic [1:0]  clkSrc;
		logic        syncMode;
		logic        overSel;
		logic [15:0] clkDiv;
		logic [2:0]  fracPart;
		logic [2:0]  prescale;
		logic [15:0] divCnt;
		logic [3:0]  sampIdx;
		logic        sampleTick;
		logic        baudTick;
	} ubrg_state_t;

endpackage : ubrg_pkg

// ---- src/ubrg_pin_sync.sv ----
// Two-flop synchroniser and rising-edge detector for the external serial clock pin.
// Assumes the pin is asynchronous to sys_clk and slower than it by the margin the far end keeps.
`timescale 1ns/1ns

module ubrg_pin_sync (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pinIn,
	output logic      riseEdge
);

	ubrg_pkg::ubrg_pin_state_t st;
	ubrg_pkg::ubrg_pin_state_t next_st;

	// The first flop feeds only the second; the edge is taken between the second and third.
	always_comb begin
		next_st      = st;
		next_st.meta = pinIn;
		next_st.sync = st.meta;
		next_st.prev = st.sync;
		next_st.rise = st.sync & ~st.prev;
	end

	// One register bank for the whole state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign riseEdge = st.rise;

	// A registered edge pulse never lasts two cycles.
	edge_single_a: assert property (@(posedge sys_clk) disable iff (rst)
		riseEdge |=> !riseEdge) else $error("external edge pulse longer than one cycle");

endmodule : ubrg_pin_sync

// ---- src/ubrg_baud_gen.sv ----
// Baud rate generator with APB register access, integer and fractional division.
// Assumes sys_clk is the peripheral clock and funcClkEn is the functional clock gate from power control.
`timescale 1ns/1ns
`include "ubrg_cfg.svh"

module ubrg_baud_gen (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        funcClkEn,
	input  wire logic        serialClkPin,
	output logic             sampleTick,
	output logic             baudTick
);

	ubrg_pkg::ubrg_state_t st;
	ubrg_pkg::ubrg_state_t next_st;

	logic        extEdge;
	logic        apbWr;
	logic        mapped;
	logic        srcTick;
	logic        syncExt;
	logic        fracOn;
	logic        stretchNow;
	logic [3:0]  lastIdx;
	logic [15:0] target;
	logic [31:0] mergedMode;
	logic [31:0] mergedDiv;

	// Applies byte enables of a write on top of the current register word.
	function automatic logic [31:0] byteMerge(input logic [31:0] oldWord, input logic [31:0] newWord,
		input logic [3:0] strb);
		logic [31:0] res;
		res = oldWord;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = newWord[8*i +: 8];
			end
		end
		return res;
	endfunction : byteMerge

	// Packs the mode fields into their register word.
	function automatic logic [31:0] modeWord(input ubrg_pkg::ubrg_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`UBRG_MODE_OPMODE_LSB +: 4] = s.opMode;
		w[`UBRG_MODE_CLKSRC_LSB +: 2] = s.clkSrc;
		w[`UBRG_MODE_SYNC_BIT]        = s.syncMode;
		w[`UBRG_MODE_OVER_BIT]        = s.overSel;
		return w;
	endfunction : modeWord

	// Packs the divisor fields into their register word.
	function automatic logic [31:0] divWord(input ubrg_pkg::ubrg_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`UBRG_DIV_CD_LSB +: 16] = s.clkDiv;
		w[`UBRG_DIV_FP_LSB +: 3]  = s.fracPart;
		return w;
	endfunction : divWord

	// Read word for an offset; unmapped offsets read as zero.
	function automatic logic [31:0] readWord(input logic [11:0] addr, input ubrg_pkg::ubrg_state_t s,
		input logic gate);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (addr)
			`UBRG_OFS_MODE: w = modeWord(s);
			`UBRG_OFS_DIV:  w = divWord(s);
			`UBRG_OFS_STAT: begin
				w[`UBRG_STAT_CNT_LSB +: 16] = s.divCnt;
				w[`UBRG_STAT_IDX_LSB +: 4]  = s.sampIdx;
				w[`UBRG_STAT_GATE_BIT]      = gate;
			end
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction : readWord

	// External clock pin enters through its own synchroniser.
	ubrg_pin_sync u_pin_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pinIn    (serialClkPin),
		.riseEdge (extEdge)
	);

	// Zero-wait slave: the access phase always completes in its first cycle.
	assign mapped  = (paddr == `UBRG_OFS_MODE) || (paddr == `UBRG_OFS_DIV) || (paddr == `UBRG_OFS_STAT);
	assign apbWr   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Source selection, mode decoding and the length of the current divider period.
	always_comb begin
		case (st.clkSrc)
			`UBRG_SRC_PCLK: srcTick = 1'b1;
			`UBRG_SRC_EXT:  srcTick = extEdge;
			default:        srcTick = (st.prescale == `UBRG_PRESCALE_LAST);
		endcase
		syncExt    = st.syncMode && (st.clkSrc == `UBRG_SRC_EXT);
		fracOn     = !st.syncMode && (st.opMode == `UBRG_OPMODE_NORMAL) && (st.fracPart != 3'h0);
		lastIdx    = st.overSel ? `UBRG_LAST_IDX_X8 : `UBRG_LAST_IDX_X16;
		// Stretched periods are the first fracPart of each run of eight, so the error never builds up.
		stretchNow = fracOn && (st.sampIdx[2:0] < st.fracPart);
		target     = st.clkDiv - 16'h0001 + {15'h0000, stretchNow};
	end

	// Register writes, bus read data and the divider chain.
	always_comb begin
		next_st            = st;
		next_st.sampleTick = 1'b0;
		next_st.baudTick   = 1'b0;
		mergedMode         = byteMerge(modeWord(st), pwdata, pstrb);
		mergedDiv          = byteMerge(divWord(st), pwdata, pstrb);

		// Read data is latched in the setup phase so it stands through the access phase.
		if (psel && !penable) begin
			next_st.prdata = readWord(paddr, st, funcClkEn);
		end

		// Writes do not depend on the functional gate, so software may configure a stopped port.
		if (apbWr && paddr == `UBRG_OFS_MODE) begin
			next_st.opMode   = mergedMode[`UBRG_MODE_OPMODE_LSB +: 4];
			next_st.clkSrc   = mergedMode[`UBRG_MODE_CLKSRC_LSB +: 2];
			next_st.syncMode = mergedMode[`UBRG_MODE_SYNC_BIT];
			next_st.overSel  = mergedMode[`UBRG_MODE_OVER_BIT];
		end
		if (apbWr && paddr == `UBRG_OFS_DIV) begin
			next_st.clkDiv   = mergedDiv[`UBRG_DIV_CD_LSB +: 16];
			next_st.fracPart = mergedDiv[`UBRG_DIV_FP_LSB +: 3];
		end

		// With the gate low every counter holds, so a restart picks up mid-period.
		if (funcClkEn) begin
			next_st.prescale = st.prescale + 3'h1;
			if (syncExt) begin
				next_st.sampleTick = extEdge;
				next_st.baudTick   = extEdge;
				next_st.divCnt     = 16'h0000;
				next_st.sampIdx    = 4'h0;
			end else if (srcTick && st.clkDiv != 16'h0000) begin
				if (st.divCnt >= target) begin
					// A divisor of one with no stretch gives target zero, so every source tick passes.
					next_st.sampleTick = 1'b1;
					next_st.divCnt     = 16'h0000;
					if (st.syncMode) begin
						next_st.baudTick = 1'b1;
						next_st.sampIdx  = 4'h0;
					end else if (st.sampIdx >= lastIdx) begin
						next_st.baudTick = 1'b1;
						next_st.sampIdx  = 4'h0;
					end else begin
						next_st.sampIdx = st.sampIdx + 4'h1;
					end
				end else begin
					next_st.divCnt = st.divCnt + 16'h0001;
				end
			end
		end
	end

	// One register bank for the whole state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st          <= '0;
			st.opMode   <= `UBRG_RST_OPMODE;
			st.clkSrc   <= `UBRG_RST_CLKSRC;
			st.clkDiv   <= `UBRG_RST_CLKDIV;
			st.fracPart <= `UBRG_RST_FRAC;
		end else begin
			st <= next_st;
		end
	end

	assign prdata     = st.prdata;
	assign sampleTick = st.sampleTick;
	assign baudTick   = st.baudTick;

	// Checking helpers: cycles between sampling ticks and whether the last period ran undisturbed.
	logic [16:0] gapCnt;
	logic        cfgDirty;
	logic        stretchSeen;

	// The gap counter restarts at each tick; any write or gated cycle spoils the next measurement.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gapCnt      <= 17'h0_0000;
			cfgDirty    <= 1'b1;
			stretchSeen <= 1'b0;
		end else begin
			gapCnt      <= st.sampleTick ? 17'h0_0001 : gapCnt + 17'h0_0001;
			cfgDirty    <= (apbWr || !funcClkEn) ? 1'b1 : (st.sampleTick ? 1'b0 : cfgDirty);
			stretchSeen <= (next_st.sampleTick && !syncExt) ? stretchNow : stretchSeen;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// A zero divisor starves the chain outside the direct external mode.
	zero_div_quiet_a: assert property (
		(st.clkDiv == 16'h0000 && !syncExt) |=> !sampleTick) else $error("tick produced with zero divisor");

	// Bypass: every source tick becomes a sampling tick one cycle later.
	bypass_pass_a: assert property (
		(st.clkDiv == 16'h0001 && !fracOn && !syncExt && srcTick && funcClkEn) |=> sampleTick)
		else $error("divisor one did not pass the source through");

	// The divided peripheral source ticks once every eight cycles.
	prescale_gap_a: assert property (
		(st.clkSrc == 2'h1 && srcTick && funcClkEn) ##1 (st.clkSrc == 2'h1 && funcClkEn)[*7]
		##1 (st.clkSrc == 2'h1) |-> srcTick)
		else $error("divided peripheral source not one in eight");

	// Undisturbed periods from the peripheral clock last divisor cycles plus any stretch.
	period_length_a: assert property (
		(sampleTick && !cfgDirty && st.clkSrc == `UBRG_SRC_PCLK && !st.syncMode && st.clkDiv > 16'h0001)
		|-> gapCnt == {1'b0, st.clkDiv} + {16'h0000, stretchSeen})
		else $error("sampling period length wrong");

	// In asynchronous mode a bit tick closes an oversampling run; the first tick after a mode write is a transition.
	async_baud_a: assert property (
		(baudTick && !st.syncMode && !cfgDirty) |-> (sampleTick && st.sampIdx == 4'h0 && $past(st.sampIdx) == lastIdx))
		else $error("bit tick not at end of oversampling run");

	// Synchronous mode applies no oversampling division.
	sync_equal_a: assert property (
		(st.syncMode && $past(st.syncMode)) |-> (baudTick == sampleTick)) else $error("sync bit clock oversampled");

	// Direct external clock in synchronous mode ignores the divisor.
	sync_ext_direct_a: assert property (
		(syncExt && extEdge && funcClkEn) |=> baudTick) else $error("external edge not passed in sync mode");

	// With the gate low the chain holds its place.
	gated_hold_a: assert property (
		!funcClkEn |=> ($stable(st.divCnt) && $stable(st.sampIdx) && !sampleTick && !baudTick))
		else $error("divider moved while gated");

	// Divisor writes land even while the functional clock is gated.
	gated_write_a: assert property (
		(apbWr && paddr == `UBRG_OFS_DIV && pstrb == 4'hF && !funcClkEn) |=> st.clkDiv == $past(pwdata[15:0]))
		else $error("divisor write lost while gated");

	// Outside normal mode, or with no fraction, an undisturbed period is exactly the divisor.
	frac_mode_a: assert property (
		(sampleTick && !cfgDirty && st.clkSrc == `UBRG_SRC_PCLK && st.clkDiv > 16'h0001
		&& (st.opMode != `UBRG_OPMODE_NORMAL || st.fracPart == 3'h0)) |-> gapCnt == {1'b0, st.clkDiv})
		else $error("fraction active outside normal mode");

	async_bit_c: cover property (baudTick && !st.syncMode && st.overSel);
	frac_stretch_c: cover property (sampleTick && stretchSeen && !cfgDirty);
	sync_ext_c: cover property (syncExt && baudTick);
	gated_resume_c: cover property (!funcClkEn ##1 funcClkEn ##[1:40] sampleTick);

endmodule : ubrg_baud_gen

// ---- test/ubrg_remote_clk.sv ----
// Model of the remote serial device that may supply the external serial clock.
// Assumes the bench raises run only while the external clock source is selected.
`timescale 1ns/1ns

module ubrg_remote_clk #(
	parameter int HALF_NS = 200
) (
	input  wire logic run,
	output logic      clkOut
);
	// Each phase lasts five peripheral periods, so the rate stays ten times below the peripheral clock.
	// The fixed offset keeps pin edges clear of the sys_clk edges, so the synchronised edge spacing is exact.
	initial begin
		clkOut = 1'b0;
		#13;
		forever begin
			#HALF_NS;
			if (run || clkOut) clkOut = ~clkOut; // Finishes a high phase, then stands still low.
		end
	end
endmodule : ubrg_remote_clk

// ---- test/ubrg_baud_gen_tb.sv ----
// Self-checking bench of the baud rate generator: APB setup, tick spacing and clock gating.
// Assumes the design answers APB with pready and gives its ticks as one-cycle pulses.
`timescale 1ns/1ns
`include "ubrg_cfg.svh"

module ubrg_baud_gen_tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        funcClkEn = 1'b1;
	logic        extRun = 1'b0;
	logic [31:0] prdata, rv, s1;
	logic        pready, pslverr, pin, sampleTick, baudTick, ev;
	logic [31:0] seed = 32'h0000_9e6d;
	int          n_mismatch = 0;
	int          compares = 0;
	logic [9:0]  cm [8] = '{10'h200, 10'h000, 10'h100, 10'h210, 10'h120, 10'h002, 10'h130, 10'h230};
	logic [18:0] cdv [8] = '{19'h0_0003, 19'h0_0001, 19'h0_0001, 19'h3_0002, 19'h0_0005, 19'h5_0004,
		19'h0_0007, 19'h0_0002};

	ubrg_baud_gen i_ubrg_baud_gen (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .funcClkEn(funcClkEn), .serialClkPin(pin),
		.sampleTick(sampleTick), .baudTick(baudTick));

	ubrg_remote_clk i_ubrg_remote_clk (.run(extRun), .clkOut(pin));

	// The 25 MHz peripheral clock.
	always #20 sys_clk = ~sys_clk;

	// Xorshift step of the fixed-seed stimulus.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// Cycles between bit clocks; the pin model gives one rising edge every ten cycles.
	function automatic int expPer(input logic [9:0] m, input logic [18:0] d);
		int s, p;
		s = (m[5:4] == 2'h0) ? 1 : (m[5:4] == 2'h3) ? 10 : 8;
		if (m[8]) p = (m[5:4] == 2'h3) ? 1 : d[15:0];
		else p = (2 - m[9]) * (8 * d[15:0] + ((m[3:0] == 4'h0) ? d[18:16] : 0));
		return p * s;
	endfunction : expPer

	// Sampling ticks that fall in one bit period.
	function automatic int expSmp(input logic [9:0] m);
		return m[8] ? 1 : (m[9] ? 8 : 16);
	endfunction : expSmp

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("Counts: compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			chk(0, 1, "apb timeout");
			conclude();
		end
	endtask : apb

	// Waits for a bit clock, then counts cycles and sampling ticks up to the next one.
	task automatic measure(output int per, output int ns);
		int k;
		k = 0;
		per = 0;
		ns = 0;
		do begin
			@(negedge sys_clk);
			k++;
		end while (baudTick !== 1'b1 && k < 3000);
		do begin
			@(negedge sys_clk);
			per++;
			ns += (sampleTick === 1'b1);
		end while (baudTick !== 1'b1 && per < 3000);
		if (k >= 3000 || per >= 3000) begin
			chk(0, 1, "tick timeout");
			conclude();
		end
	endtask : measure

	// Programs one setting and checks the settled bit period; the first period may be a transition.
	task automatic cfgRun(input logic [9:0] m, input logic [18:0] d);
		int per, ns;
		extRun <= (m[5:4] == 2'h3);
		apb(1'b1, `UBRG_OFS_MODE, {22'h00_0000, m}, rv, ev);
		apb(1'b1, `UBRG_OFS_DIV, {13'h0000, d}, rv, ev);
		apb(1'b0, `UBRG_OFS_DIV, 32'h0000_0000, rv, ev);
		chk(rv, {13'h0000, d}, "divider readback");
		measure(per, ns);
		measure(per, ns);
		chk(per, expPer(m, d), "bit period");
		chk(ns, expSmp(m), "samples per bit");
	endtask : cfgRun

	// Main sequence: reset state, refused access, corner settings, random settings, gating.
	initial begin
		int per, ns;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, `UBRG_OFS_MODE, 32'h0000_0000, rv, ev);
		chk(rv, 32'h0000_0000, "mode after reset");
		apb(1'b0, `UBRG_OFS_DIV, 32'h0000_0000, rv, ev);
		chk(rv, 32'h0000_0000, "divider after reset");
		per = 0;
		repeat (100) begin
			@(negedge sys_clk);
			per += (sampleTick === 1'b1 || baudTick === 1'b1);
		end
		chk(per, 0, "ticks with zero divisor");
		apb(1'b1, 12'h00C, 32'hFFFF_FFFF, rv, ev);
		chk(ev, 1'b1, "unmapped write error");
		apb(1'b0, 12'h00C, 32'h0000_0000, rv, ev);
		chk(rv, 32'h0000_0000, "unmapped read data");
		chk(ev, 1'b1, "unmapped read error");
		for (int i = 0; i < 16; i++) begin
			if (i < 8) begin
				cfgRun(cm[i], cdv[i]);
			end else begin
				seed = xs(seed);
				// Each drawn divisor lies between 2 and 9 with a fraction of 0 to 7, and the external source is never drawn.
				cfgRun({seed[9:8], 2'h0, (seed[5:4] == 2'h3) ? 2'h1 : seed[5:4], 3'h0, seed[0]},
					{seed[18:16], 13'h0000, seed[12:10]} + 19'h0_0002);
			end
		end
		// Gated clock: counters freeze, configuration still accepted, new setting used after restart.
		cfgRun(10'h200, 19'h0_0003);
		@(posedge sys_clk);
		funcClkEn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		apb(1'b0, `UBRG_OFS_STAT, 32'h0000_0000, s1, ev);
		chk(s1[20], 1'b0, "gate status");
		per = 0;
		repeat (40) begin
			@(negedge sys_clk);
			per += (sampleTick === 1'b1 || baudTick === 1'b1);
		end
		chk(per, 0, "ticks while gated");
		apb(1'b0, `UBRG_OFS_STAT, 32'h0000_0000, rv, ev);
		chk(rv[19:0], s1[19:0], "frozen divider state");
		apb(1'b1, `UBRG_OFS_DIV, 32'h0000_0005, rv, ev);
		apb(1'b0, `UBRG_OFS_DIV, 32'h0000_0000, rv, ev);
		chk(rv, 32'h0000_0005, "write while gated");
		funcClkEn <= 1'b1;
		measure(per, ns);
		measure(per, ns);
		chk(per, expPer(10'h200, 19'h0_0005), "period after restart");
		conclude();
	end
endmodule : ubrg_baud_gen_tb
